// ===== rtl/fsv_consts.svh
// Offsets, field positions, reset values for the special-value unit
`ifndef FSV_CONSTS_SVH
`define FSV_CONSTS_SVH

// Register byte offsets on APB
`define FSV_OFS_STATUS   8'h00
`define FSV_OFS_OPA      8'h04
`define FSV_OFS_OPB      8'h08
`define FSV_OFS_RAW      8'h0C
`define FSV_OFS_CMD      8'h10
`define FSV_OFS_RESULT   8'h14
`define FSV_OFS_HOST     8'h18
`define FSV_OFS_EXC      8'h1C

// Status/control field positions
`define FSV_BIT_IOC      0
`define FSV_BIT_UFC      3
`define FSV_BIT_IXC      4
`define FSV_BIT_IOE      8
`define FSV_TRAP_LO      8
`define FSV_TRAP_HI      12
`define FSV_BIT_IDC      15
`define FSV_BIT_FZ       24
`define FSV_BIT_DN       25
`define FSV_CC_LO        28
`define FSV_CC_HI        31

// Writable bits of the status/control register
`define FSV_STATUS_MASK  32'hF3009F19
`define FSV_STATUS_RST   32'h00000000

// Command word fields
`define FSV_CMD_TINY     4
`define FSV_CMD_INX      5

// Single-precision special values
`define FSV_DEF_NAN      32'h7FC00000
`define FSV_EXP_ONES     8'hFF

// Condition codes N Z C V
`define FSV_CC_LT        4'h8
`define FSV_CC_EQ        4'h6
`define FSV_CC_GT        4'h2
`define FSV_CC_UN        4'h3

`endif

// ===== rtl/fsv_pkg.sv
// Types shared by the special-value unit
package fsv_pkg;
  typedef enum logic [2:0] {
    FSV_OP_XFER  = 3'h0,
    FSV_OP_COPY  = 3'h1,
    FSV_OP_ABS   = 3'h2,
    FSV_OP_NEG   = 3'h3,
    FSV_OP_ARITH = 3'h4,
    FSV_OP_CMP   = 3'h5,
    FSV_OP_CMPE  = 3'h6,
    FSV_OP_FLAGS = 3'h7
  } fsv_op_t;
endpackage

// ===== rtl/fsv_special.sv
// Special-value and exception-flag unit with APB register access
//
// Operation
// - Non-fast NaN arithmetic bounces to support code
// - Transfers move NaNs untouched, no flags
// - Copy, abs, negate alter only sign
// - Fast mode: signaling NaN arithmetic sets invalid
// - Fast mode NaN arithmetic returns default NaN
// - Compares write codes; flags op copies out
// - Numeric compares give less, equal, greater
// - Compare signaling NaN: unordered, invalid, trap when bit 8 set
// - Compare quiet NaN: unordered, no invalid
// - Signal compare: any NaN raises invalid
// - Tininess after rounding, subnormalization loss
// - Flush mode: tiny result becomes plus zero
// - Non-flush tiny risk bounces; else inexact only
// - Exceptional op pends; next op enters handling
// - Entry keeps sources, destination unwritten
// - No intermediate result written; handler may write destination
// - Flush mode follows status bit 24
// - Flush mode zeroes subnormal arithmetic inputs
// - Exceptions from flushed zero signal normally
// - Input flush and result flush flags
// - Default NaN enable bit 25, reset 0
// - Default NaN mode returns default NaN only in fast mode
// - Transfers and sign ops keep NaN payload
// - Default NaN is 7FC00000
// - Fast mode needs flush, default NaN, no traps
// - Top fraction bit 0 signaling, 1 quiet
// - Underflow flag sticky until software write
`include "fsv_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module fsv_special (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             exc_pending,
  output logic      [3:0]  host_status_flags
);
  import fsv_pkg::*;

  logic [31:0] status_reg;
  logic [31:0] opa_reg;
  logic [31:0] opb_reg;
  logic [31:0] raw_reg;
  logic [31:0] result_reg;
  logic [3:0]  host_reg;
  logic        pend_reg;
  logic        entered_reg;
  logic [31:0] status_next;
  logic [31:0] prdata_next;

  // Bus decode; the slave never stalls, so every access ends at once
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire hit_stat = (paddr == `FSV_OFS_STATUS);
  wire hit_opa  = (paddr == `FSV_OFS_OPA);
  wire hit_opb  = (paddr == `FSV_OFS_OPB);
  wire hit_raw  = (paddr == `FSV_OFS_RAW);
  wire hit_cmd  = (paddr == `FSV_OFS_CMD);
  wire hit_res  = (paddr == `FSV_OFS_RESULT);
  wire hit_host = (paddr == `FSV_OFS_HOST);
  wire hit_exc  = (paddr == `FSV_OFS_EXC);
  wire mapped   = hit_stat | hit_opa | hit_opb | hit_raw | hit_cmd |
                  hit_res | hit_host | hit_exc;
  wire issue    = wr & hit_cmd;

  // Mode bits
  wire fz_mode  = status_reg[`FSV_BIT_FZ];
  wire dn_mode  = status_reg[`FSV_BIT_DN];
  wire no_traps = ~|status_reg[`FSV_TRAP_HI:`FSV_TRAP_LO];
  wire fast     = fz_mode & dn_mode & no_traps;
  wire invalid_op_trap_enable      = status_reg[`FSV_BIT_IOE];

  // Operand classes; top fraction bit tells quiet from signaling
  wire a_exp1  = (opa_reg[30:23] == `FSV_EXP_ONES);
  wire b_exp1  = (opb_reg[30:23] == `FSV_EXP_ONES);
  wire a_nan   = a_exp1 & (|opa_reg[22:0]);
  wire b_nan   = b_exp1 & (|opb_reg[22:0]);
  wire a_snan  = a_nan & ~opa_reg[22];
  wire b_snan  = b_nan & ~opb_reg[22];
  wire any_nan = a_nan | b_nan;
  wire any_sn  = a_snan | b_snan;
  wire a_sub   = (opa_reg[30:23] == 8'h00) & (|opa_reg[22:0]);
  wire b_sub   = (opb_reg[30:23] == 8'h00) & (|opb_reg[22:0]);

  // Command fields
  wire [2:0] op_bits = pwdata[2:0];
  wire       tiny    = pwdata[`FSV_CMD_TINY];
  wire       inx     = pwdata[`FSV_CMD_INX];
  fsv_op_t   op;
  assign op = fsv_op_t'(op_bits);

  // Numeric compare on magnitudes; both zeros of either sign are equal
  wire both_zero = ~|opa_reg[30:0] & ~|opb_reg[30:0];
  wire same_bits = (opa_reg == opb_reg);
  wire mag_lt    = (opa_reg[30:0] < opb_reg[30:0]);
  wire mag_gt    = (opa_reg[30:0] > opb_reg[30:0]);
  wire num_lt    = (opa_reg[31] != opb_reg[31]) ? opa_reg[31] :
                   (opa_reg[31] ? mag_gt : mag_lt);
  wire [3:0] num_cc = (both_zero | same_bits) ? `FSV_CC_EQ :
                      (num_lt ? `FSV_CC_LT : `FSV_CC_GT);

  // Per-op outcome of one issued instruction
  logic        ex_res_we;
  logic [31:0] ex_res;
  logic        ex_cc_we;
  logic [3:0]  ex_cc;
  logic        ex_ioc;
  logic        ex_ufc;
  logic        ex_idc;
  logic        ex_ixc;
  logic        ex_bounce;
  logic        ex_host_we;

  // Dispatch; flush mode only reaches the arithmetic class
  always_comb begin
    ex_res_we  = 1'b0;
    ex_res     = opa_reg;
    ex_cc_we   = 1'b0;
    ex_cc      = num_cc;
    ex_ioc     = 1'b0;
    ex_ufc     = 1'b0;
    ex_idc     = 1'b0;
    ex_ixc     = 1'b0;
    ex_bounce  = 1'b0;
    ex_host_we = 1'b0;
    unique case (op)
      FSV_OP_XFER: begin
        ex_res_we = 1'b1;
        ex_res    = opa_reg;
      end
      FSV_OP_COPY: begin
        ex_res_we = 1'b1;
        ex_res    = opa_reg;
      end
      FSV_OP_ABS: begin
        ex_res_we = 1'b1;
        ex_res    = {1'b0, opa_reg[30:0]};
      end
      FSV_OP_NEG: begin
        ex_res_we = 1'b1;
        ex_res    = {~opa_reg[31], opa_reg[30:0]};
      end
      FSV_OP_ARITH: begin
        // Tiny flag comes from the rounder, judged after rounding
        ex_idc = fz_mode & (a_sub | b_sub);
        if (any_nan & ~fast) begin
          ex_bounce = 1'b1;
        end else if (any_nan) begin
          ex_res_we = 1'b1;
          ex_res    = `FSV_DEF_NAN;
          ex_ioc    = any_sn;
        end else if (tiny & fz_mode) begin
          ex_res_we = 1'b1;
          ex_res    = 32'h00000000;
          ex_ufc    = 1'b1;
        end else if (tiny) begin
          ex_bounce = 1'b1;
        end else begin
          // Raw result already reflects zeroed inputs and their flags
          ex_res_we = 1'b1;
          ex_res    = raw_reg;
          ex_ixc    = inx;
        end
      end
      FSV_OP_CMP: begin
        ex_cc_we  = 1'b1;
        ex_cc     = any_nan ? `FSV_CC_UN : num_cc;
        ex_ioc    = any_sn;
        ex_bounce = any_sn & invalid_op_trap_enable;
      end
      FSV_OP_CMPE: begin
        ex_cc_we  = 1'b1;
        ex_cc     = any_nan ? `FSV_CC_UN : num_cc;
        ex_ioc    = any_nan;
        ex_bounce = any_nan & invalid_op_trap_enable;
      end
      FSV_OP_FLAGS: begin
        ex_host_we = 1'b1;
      end
    endcase
  end

  // An op issued while pending starts handling instead of running
  wire run   = issue & ~pend_reg;
  wire enter = issue & pend_reg;
  wire st_we = wr & hit_stat;

  // Sticky flags: the software write lands first, events OR on top,
  // so an event in the clearing cycle is kept
  always_comb begin
    status_next = status_reg;
    if (st_we) begin
      status_next = pwdata & `FSV_STATUS_MASK;
    end
    if (run) begin
      status_next[`FSV_BIT_IOC] = status_next[`FSV_BIT_IOC] | ex_ioc;
      status_next[`FSV_BIT_UFC] = status_next[`FSV_BIT_UFC] | ex_ufc;
      status_next[`FSV_BIT_IDC] = status_next[`FSV_BIT_IDC] | ex_idc;
      status_next[`FSV_BIT_IXC] = status_next[`FSV_BIT_IXC] | ex_ixc;
      if (ex_cc_we) begin
        status_next[`FSV_CC_HI:`FSV_CC_LO] = ex_cc;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `FSV_STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // Operand and raw-result holders; never touched by exception entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_reg <= 32'h00000000;
      opb_reg <= 32'h00000000;
      raw_reg <= 32'h00000000;
    end else begin
      if (wr & hit_opa) opa_reg <= pwdata;
      if (wr & hit_opb) opb_reg <= pwdata;
      if (wr & hit_raw) raw_reg <= pwdata;
    end
  end

  // Destination: a bounced op leaves it; handler may write it directly
  wire res_load = run & ex_res_we & ~ex_bounce;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 32'h00000000;
    end else if (wr & hit_res) begin
      result_reg <= pwdata;
    end else if (res_load) begin
      result_reg <= ex_res;
    end
  end

  // Pending state and entry marker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg    <= 1'b0;
      entered_reg <= 1'b0;
      host_reg    <= 4'h0;
    end else begin
      if (run & ex_bounce) pend_reg <= 1'b1;
      else if (enter) pend_reg <= 1'b0;
      if (enter) entered_reg <= 1'b1;
      else if (wr & hit_exc) entered_reg <= 1'b0;
      if (run & ex_host_we) begin
        host_reg <= status_reg[`FSV_CC_HI:`FSV_CC_LO];
      end
    end
  end

  // Read mux, registered so data outputs come from flip-flops
  assign prdata_next =
      hit_stat ? status_reg :
      hit_opa  ? opa_reg :
      hit_opb  ? opb_reg :
      hit_raw  ? raw_reg :
      hit_res  ? result_reg :
      hit_host ? {28'h0000000, host_reg} :
      hit_exc  ? {30'h00000000, entered_reg, pend_reg} :
      32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= prdata_next;
    end
  end

  // Fixed zero-wait answer; unmapped addresses error
  assign pready            = 1'b1;
  assign pslverr           = acc & ~mapped;
  assign exc_pending       = pend_reg;
  assign host_status_flags = host_reg;

  wire unused_rd = rd;

  // Checks on the design's own state
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire issue_ok = run & ~st_we;

  fast_nan_a: assert property (issue_ok & fast & (op == FSV_OP_ARITH) &
      any_nan |=> result_reg == `FSV_DEF_NAN)
    else $error("fast NaN arithmetic did not give default NaN");
  fast_snan_a: assert property (issue_ok & fast & (op == FSV_OP_ARITH) &
      any_sn |=> status_reg[`FSV_BIT_IOC])
    else $error("signaling NaN did not set invalid flag");
  slow_bounce_a: assert property (issue_ok & ~fast & (op == FSV_OP_ARITH) &
      any_nan |=> pend_reg & $stable(result_reg))
    else $error("non-fast NaN arithmetic did not bounce");
  neg_sign_a: assert property (issue_ok & (op == FSV_OP_NEG) |=>
      result_reg == {~$past(opa_reg[31]), $past(opa_reg[30:0])})
    else $error("negate changed more than the sign");
  qnan_cmp_a: assert property (issue_ok & (op == FSV_OP_CMP) & any_nan &
      ~any_sn & ~status_reg[`FSV_BIT_IOC] |=>
      status_reg[`FSV_CC_HI:`FSV_CC_LO] == `FSV_CC_UN &&
      !status_reg[`FSV_BIT_IOC])
    else $error("quiet NaN compare raised invalid");
  cmpe_nan_a: assert property (issue_ok & (op == FSV_OP_CMPE) & any_nan
      |=> status_reg[`FSV_BIT_IOC])
    else $error("signal compare NaN did not raise invalid");
  flush_res_a: assert property (issue_ok & fz_mode & (op == FSV_OP_ARITH)
      & ~any_nan & tiny |=> result_reg == 32'h00000000 &&
      status_reg[`FSV_BIT_UFC])
    else $error("tiny result not flushed");
  ufc_sticky_a: assert property (status_reg[`FSV_BIT_UFC] & ~st_we |=>
      status_reg[`FSV_BIT_UFC])
    else $error("underflow flag dropped without a write");
  pend_entry_a: assert property (enter & ~(wr & hit_res) |=>
      !pend_reg && entered_reg && $stable(result_reg))
    else $error("exception entry mishandled");
  host_copy_a: assert property (issue_ok & (op == FSV_OP_FLAGS) |=>
      host_reg == $past(status_reg[`FSV_CC_HI:`FSV_CC_LO]))
    else $error("flags transfer wrong");

  fast_nan_c: cover property (run & fast & (op == FSV_OP_ARITH) & any_nan);
  bounce_c:   cover property (run & ex_bounce ##[1:20] enter);
  unord_c:    cover property (run & (op == FSV_OP_CMPE) & any_nan);
  flush_c:    cover property (run & fz_mode & tiny & (op == FSV_OP_ARITH));

endmodule

`default_nettype wire

// ===== tb/fsv_host_model.sv
// Host core model that issues coprocessor requests over APB
`timescale 1ns/100ps
`default_nettype none

module fsv_host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  // Bus idle from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
  end

  // Setup then access; held until pready is seen at a rising edge
  task automatic xfer(input  logic        w,
                      input  logic [7:0]  a,
                      input  logic [31:0] d,
                      output logic [31:0] r,
                      output logic        e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No wait count assumed; only the bench watchdog ends a hang
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d; // Released data inverted so stale values show
  endtask
endmodule

`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the special-value unit
`include "fsv_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module tb;
  import fsv_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        exc_pending;
  logic [3:0]  host_status_flags;
  int          error_cnt = 0;
  int          compares = 0;
  // Compare table: operands, op, codes, invalid
  localparam logic [31:0] CA [6] = '{32'h3F800000, 32'h40000000,
    32'h40000000, 32'h7FC00000, 32'h7F800001, 32'h7FC00000};
  localparam logic [31:0] CB [6] = '{32'h40000000, 32'h40000000,
    32'h3F800000, 32'h3F800000, 32'h3F800000, 32'h3F800000};
  localparam fsv_op_t     CO [6] = '{FSV_OP_CMPE, FSV_OP_CMP, FSV_OP_CMP,
    FSV_OP_CMP, FSV_OP_CMP, FSV_OP_CMPE};
  localparam logic [3:0]  CC [6] = '{`FSV_CC_LT, `FSV_CC_EQ, `FSV_CC_GT,
    `FSV_CC_UN, `FSV_CC_UN, `FSV_CC_UN};
  localparam logic        CV [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  fsv_special u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exc_pending(exc_pending), .host_status_flags(host_status_flags));
  fsv_host_model u_host (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    u_host.xfer(1'b0, a, 32'h00000000, r, e);
    chk(r & m, exp);
  endtask
  task automatic op(input fsv_op_t o, input logic t, input logic x);
    wr(`FSV_OFS_CMD, {26'h0000000, x, t, 1'b0, o});
    // Registered outputs update after the access edge; look once settled
    @(negedge pclk);
  endtask
  // Leave a pending state: next op enters handling, then clear entry
  task automatic clr_exc;
    op(FSV_OP_XFER, 1'b0, 1'b0);
    wr(`FSV_OFS_EXC, 32'h00000002);
  endtask
  task automatic sgn(input fsv_op_t o, input logic [31:0] a,
                     input logic [31:0] exp);
    wr(`FSV_OFS_OPA, a);
    op(o, 1'b0, 1'b0);
    chk_reg(`FSV_OFS_RESULT, 32'hFFFFFFFF, exp);
    chk_reg(`FSV_OFS_STATUS, 32'h00008019, 32'h00000000);
    chk_bit(exc_pending, 1'b0);
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    chk_reg(`FSV_OFS_STATUS, 32'hFFFFFFFF, `FSV_STATUS_RST);
    chk_reg(`FSV_OFS_EXC, 32'h00000003, 32'h00000000);
    chk_bit(exc_pending, 1'b0);
    chk_bit(pready, 1'b1);
    u_host.xfer(1'b0, 8'h20, 32'h00000000, r, e);
    chk_bit(e, 1'b1);
    chk(r, 32'h00000000);
  endtask
  // Sign ops and transfers in plain, default-NaN and fast modes
  task automatic t_sign;
    logic [31:0] mode [3];
    mode = '{32'h00000000, 32'h02000000, 32'h03000000};
    for (int i = 0; i < 3; i++) begin
      wr(`FSV_OFS_STATUS, mode[i]);
      sgn(FSV_OP_XFER, 32'h7F800001, 32'h7F800001);
      sgn(FSV_OP_COPY, 32'h7FC12345, 32'h7FC12345);
      sgn(FSV_OP_ABS, 32'hFF812345, 32'h7F812345);
      sgn(FSV_OP_NEG, 32'h7FC00001, 32'hFFC00001);
      sgn(FSV_OP_ABS, 32'h80000001, 32'h00000001);
    end
  endtask
  task automatic t_bounce;
    wr(`FSV_OFS_STATUS, 32'h00000000);
    wr(`FSV_OFS_RESULT, 32'h12345678);
    wr(`FSV_OFS_OPA, 32'h7FC00000);
    wr(`FSV_OFS_OPB, 32'h3F800000);
    op(FSV_OP_ARITH, 1'b0, 1'b0);
    chk_bit(exc_pending, 1'b1);
    chk_reg(`FSV_OFS_OPA, 32'hFFFFFFFF, 32'h7FC00000);
    op(FSV_OP_COPY, 1'b0, 1'b0);
    chk_bit(exc_pending, 1'b0);
    chk_reg(`FSV_OFS_EXC, 32'h00000003, 32'h00000002);
    chk_reg(`FSV_OFS_RESULT, 32'hFFFFFFFF, 32'h12345678);
    wr(`FSV_OFS_EXC, 32'h00000002);
    chk_reg(`FSV_OFS_EXC, 32'h00000003, 32'h00000000);
    wr(`FSV_OFS_RESULT, 32'h00800000);
    chk_reg(`FSV_OFS_RESULT, 32'hFFFFFFFF, 32'h00800000);
    wr(`FSV_OFS_OPA, 32'h3F800000);
    op(FSV_OP_ARITH, 1'b1, 1'b0);
    chk_bit(exc_pending, 1'b1);
    clr_exc();
    wr(`FSV_OFS_STATUS, 32'h03000100);
    wr(`FSV_OFS_OPA, 32'h7FC00000);
    op(FSV_OP_ARITH, 1'b0, 1'b0);
    chk_bit(exc_pending, 1'b1);
    clr_exc();
    wr(`FSV_OFS_STATUS, 32'h03000200);
    op(FSV_OP_ARITH, 1'b0, 1'b0);
    chk_bit(exc_pending, 1'b1);
    clr_exc();
  endtask
  task automatic t_fast;
    wr(`FSV_OFS_STATUS, 32'h03000000);
    wr(`FSV_OFS_OPA, 32'h7F800001);
    wr(`FSV_OFS_OPB, 32'h3F800000);
    op(FSV_OP_ARITH, 1'b0, 1'b0);
    chk_reg(`FSV_OFS_RESULT, 32'hFFFFFFFF, `FSV_DEF_NAN);
    chk_reg(`FSV_OFS_STATUS, 32'h00000001, 32'h00000001);
    chk_bit(exc_pending, 1'b0);
    wr(`FSV_OFS_STATUS, 32'h03000000);
    wr(`FSV_OFS_OPA, 32'h3F800000);
    wr(`FSV_OFS_OPB, 32'h7FD55555);
    op(FSV_OP_ARITH, 1'b0, 1'b0);
    chk_reg(`FSV_OFS_RESULT, 32'hFFFFFFFF, `FSV_DEF_NAN);
    chk_reg(`FSV_OFS_STATUS, 32'h00000001, 32'h00000000);
  endtask
  task automatic t_flush;
    wr(`FSV_OFS_STATUS, 32'h01000000);
    wr(`FSV_OFS_RAW, 32'h40400000);
    wr(`FSV_OFS_OPB, 32'h3F800000);
    wr(`FSV_OFS_OPA, 32'h00000001);
    op(FSV_OP_ARITH, 1'b0, 1'b0);
    chk_reg(`FSV_OFS_RESULT, 32'hFFFFFFFF, 32'h40400000);
    chk_reg(`FSV_OFS_STATUS, 32'h00008019, 32'h00008000);
    wr(`FSV_OFS_OPA, 32'h3F800000);
    op(FSV_OP_ARITH, 1'b1, 1'b0);
    chk_reg(`FSV_OFS_RESULT, 32'hFFFFFFFF, 32'h00000000);
    chk_reg(`FSV_OFS_STATUS, 32'h00008019, 32'h00008008);
    chk_bit(exc_pending, 1'b0);
    op(FSV_OP_ARITH, 1'b0, 1'b0);
    chk_reg(`FSV_OFS_STATUS, 32'h00000008, 32'h00000008);
    wr(`FSV_OFS_STATUS, 32'h00000000);
    chk_reg(`FSV_OFS_STATUS, 32'h00000008, 32'h00000000);
    op(FSV_OP_ARITH, 1'b0, 1'b1);
    chk_reg(`FSV_OFS_RESULT, 32'hFFFFFFFF, 32'h40400000);
    chk_reg(`FSV_OFS_STATUS, 32'h00000019, 32'h00000010);
  endtask
  task automatic t_cmp;
    for (int i = 0; i < 6; i++) begin
      wr(`FSV_OFS_STATUS, 32'h00000000);
      wr(`FSV_OFS_OPA, CA[i]);
      wr(`FSV_OFS_OPB, CB[i]);
      op(CO[i], 1'b0, 1'b0);
      chk_reg(`FSV_OFS_STATUS, 32'hF0000001,
              {CC[i], 27'h0000000, CV[i]});
      op(FSV_OP_FLAGS, 1'b0, 1'b0);
      chk({28'h0000000, host_status_flags}, {28'h0000000, CC[i]});
      chk_reg(`FSV_OFS_HOST, 32'h0000000F, {28'h0000000, CC[i]});
    end
    wr(`FSV_OFS_STATUS, 32'h00000100);
    op(FSV_OP_CMP, 1'b0, 1'b0);
    chk_bit(exc_pending, 1'b0);
    wr(`FSV_OFS_OPA, 32'h7F800001);
    op(FSV_OP_CMP, 1'b0, 1'b0);
    chk_bit(exc_pending, 1'b1);
    clr_exc();
  endtask

  task automatic end_of_test;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Free-running 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sign();
    t_bounce();
    t_fast();
    t_flush();
    t_cmp();
    end_of_test();
  end
  // Watchdog well past the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end
endmodule

`default_nettype wire
